//--- include/charge_time_pkg.sv
package charge_time_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the AXI4-Lite bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_UNIT_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CURRENT_CONTROL = 8'h04;
   localparam logic [7:0] OFS_COMPARATOR_CONTROL = 8'h08;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_UNIT_CONTROL = 16'h0000;
   localparam logic [15:0] RST_CURRENT_CONTROL = 16'h0000;
   localparam logic [15:0] RST_COMPARATOR_CONTROL = 16'h0000;

   // Writable bit masks; everything else reads as zero
   localparam logic [15:0] MASK_UNIT_CONTROL = 16'hBFFF;
   localparam logic [15:0] MASK_CURRENT_CONTROL = 16'hFF00;
   localparam logic [15:0] MASK_COMPARATOR_CONTROL = 16'h8000;

   // ----------------------------------------------------------------
   // Edge source codes, shared by both edge channels
   // ----------------------------------------------------------------
   localparam logic [1:0] SRC_TIMER = 2'h0;
   localparam logic [1:0] SRC_OUTPUT_COMPARE_ONE = 2'h1;
   localparam logic [1:0] SRC_EDGE_PIN_TWO = 2'h2;
   localparam logic [1:0] SRC_EDGE_PIN_ONE = 2'h3;

   // Current range codes
   localparam logic [1:0] RANGE_OFF = 2'h0;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Register layouts, most significant field first
   // ----------------------------------------------------------------
   typedef struct packed {
      logic unit_enable;             // bit 15
      logic unused_14;               // bit 14
      logic idle_stop;               // bit 13
      logic delay_generation_enable; // bit 12
      logic edge_pass_enable;        // bit 11
      logic edge_order_enable;       // bit 10
      logic current_ground_control;  // bit 9
      logic trigger_output_enable;   // bit 8
      logic second_edge_polarity;    // bit 7
      logic [1:0] second_edge_source; // bits 6-5
      logic first_edge_polarity;     // bit 4
      logic [1:0] first_edge_source; // bits 3-2
      logic second_edge_seen;        // bit 1
      logic first_edge_seen;         // bit 0
   } unit_control_type;

   typedef struct packed {
      logic [5:0] current_trim;  // bits 15-10, two's complement
      logic [1:0] current_range; // bits 9-8
      logic [7:0] unused_low;    // bits 7-0
   } current_control_type;

   typedef struct packed {
      logic comparator_idle_stop; // bit 15
      logic [14:0] unused_rest;   // bits 14-0
   } comparator_control_type;

   // Edge sources bundled in select-code order
   typedef struct packed {
      logic edge_pin_one;       // code 3
      logic edge_pin_two;       // code 2
      logic output_compare_one; // code 1
      logic timer_edge;         // code 0
   } edge_sources_type;

   // Write channel states, one-hot
   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESPOND = 2'b10
   } write_state_type;

endpackage : charge_time_pkg

//--- verilog/charge_time_unit.sv
`timescale 1ns/1ps

module charge_time_unit
   import charge_time_pkg::*;
#(
   parameter int ADDR_W = 8 // Byte address width seen by the slave
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // AXI4-Lite write address
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic [2:0] S_AXI_AWPROT,
   // AXI4-Lite write data
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   // AXI4-Lite write response
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   // AXI4-Lite read address
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic [2:0] S_AXI_ARPROT,
   // AXI4-Lite read data
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   // Device power state
   input wire logic IDLE_MODE,
   // Edge sources
   input wire logic EDGE_PIN_ONE,
   input wire logic EDGE_PIN_TWO,
   input wire logic OUTPUT_COMPARE_ONE,
   input wire logic TIMER_EDGE,
   // Comparator side
   input wire logic COMPARATOR_OUT,
   input wire logic COMPARATOR_EVENT,
   output logic COMPARATOR_IRQ,
   output logic COMPARATOR_B_INPUT_ROUTE,
   // Current source side
   output logic CHARGE_ENABLE,
   output logic CURRENT_GROUND,
   output logic [5:0] CURRENT_TRIM,
   output logic [1:0] CURRENT_RANGE,
   // Unit outputs
   output logic DELAYED_PULSE_OUT,
   output logic TRIGGER_OUT
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // Offsets are only 8 bits wide
   if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr
      $error("ADDR_W must lie between 4 and 8");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   unit_control_type ctrl_r;          // Control and edge status
   current_control_type icon_r;       // Trim and range
   comparator_control_type cmp_r;     // Comparator idle behaviour
   write_state_type wr_state_r;       // Write channel state
   write_state_type wr_state_nxt;     // Next write state
   logic aw_held_r;                   // Write address captured
   logic w_held_r;                    // Write data captured
   logic [ADDR_W-1:0] aw_addr_r;      // Captured write address
   logic [31:0] w_data_r;             // Captured write data
   logic [3:0] w_strb_r;              // Captured byte strobes
   logic [1:0] bresp_r;               // Pending write response
   logic rvalid_r;                    // Read data pending
   logic [31:0] rdata_r;              // Read data
   logic [1:0] rresp_r;               // Read response
   logic wr_commit;                   // Write performed this cycle
   logic wr_hit_ctrl;                 // Write targets control
   logic wr_hit_icon;                 // Write targets current control
   logic wr_hit_cmp;                  // Write targets comparator control
   logic [15:0] wr_mask;              // Byte-lane mask, low half
   edge_sources_type sources;         // All edge sources
   logic unit_active;                 // Enabled and not idle-stopped
   logic edge_one_level;              // Selected first source level
   logic edge_two_level;              // Selected second source level
   logic edge_one_prev_r;             // Previous first source level
   logic edge_two_prev_r;             // Previous second source level
   logic edge_one_event;              // Qualified first edge
   logic edge_two_event;              // Qualified second edge
   logic edge_one_armed;              // First edge now or before
   logic trigger_r;                   // Registered trigger output
   logic ground_r;                    // Registered ground control
   logic [5:0] trim_r;                // Registered trim code
   logic [1:0] range_r;               // Registered range code

   // ----------------------------------------------------------------
   // Edge selection and qualification
   // ----------------------------------------------------------------
   assign sources = '{edge_pin_one: EDGE_PIN_ONE, edge_pin_two: EDGE_PIN_TWO,
                      output_compare_one: OUTPUT_COMPARE_ONE, timer_edge: TIMER_EDGE};

   // Enabled and not halted by Idle
   assign unit_active = ctrl_r.unit_enable && !(ctrl_r.idle_stop && IDLE_MODE);

   // Select code indexes the bundle directly; codes 3..0 are pin one..timer
   assign edge_one_level = sources[ctrl_r.first_edge_source];
   assign edge_two_level = sources[ctrl_r.second_edge_source];

   // Level history of the selected sources
   // A new select can fake an edge
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         edge_one_prev_r <= 1'b0;
         edge_two_prev_r <= 1'b0;
      end else begin
         edge_one_prev_r <= edge_one_level;
         edge_two_prev_r <= edge_two_level;
      end
   end

   // Edge matches when new level equals polarity and old one did not
   assign edge_one_event = unit_active && ctrl_r.edge_pass_enable
                           && (edge_one_level == ctrl_r.first_edge_polarity)
                           && (edge_one_prev_r != ctrl_r.first_edge_polarity);
   assign edge_two_event = unit_active && ctrl_r.edge_pass_enable
                           && (edge_two_level == ctrl_r.second_edge_polarity)
                           && (edge_two_prev_r != ctrl_r.second_edge_polarity)
                           && (!ctrl_r.edge_order_enable || edge_one_armed);

   // First edge counts in the cycle it happens, not a cycle late
   // Same-cycle pair passes ordering
   assign edge_one_armed = ctrl_r.first_edge_seen || edge_one_event;

   // ----------------------------------------------------------------
   // Pulse delay path
   // ----------------------------------------------------------------
   // Current source is steered to the comparator only in delay mode
   assign COMPARATOR_B_INPUT_ROUTE = unit_active && ctrl_r.delay_generation_enable;

   // Charging starts on the qualified edge itself; no flop in the way
   // Held until flag one is cleared
   assign CHARGE_ENABLE = COMPARATOR_B_INPUT_ROUTE && edge_one_armed;

   // Pulse follows the comparator directly, so its edge is not clocked
   assign DELAYED_PULSE_OUT = CHARGE_ENABLE && COMPARATOR_OUT;

   // Comparator interrupts are masked in Idle when asked
   assign COMPARATOR_IRQ = COMPARATOR_EVENT
                           && !(cmp_r.comparator_idle_stop && IDLE_MODE);

   // ----------------------------------------------------------------
   // Registered trigger output and outputs towards the current source
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         trigger_r <= 1'b0;
         ground_r <= 1'b0;
         trim_r <= RST_CURRENT_CONTROL[15:10];
         range_r <= RANGE_OFF;
      end else begin
         // Trigger pulses once per cycle with a qualified edge while allowed; two edges in one cycle give one pulse
         trigger_r <= ctrl_r.trigger_output_enable
                      && (edge_one_event || edge_two_event);
         ground_r <= ctrl_r.current_ground_control;
         trim_r <= icon_r.current_trim;
         // Source is off whenever the unit is inactive
         range_r <= unit_active ? icon_r.current_range : RANGE_OFF;
      end
   end

   // Codes settle a cycle late
   assign TRIGGER_OUT = trigger_r;
   assign CURRENT_GROUND = ground_r;
   assign CURRENT_TRIM = trim_r;
   assign CURRENT_RANGE = range_r;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   // Address and data may come in either order; each is held once taken
   // No new write while B stands
   assign S_AXI_AWREADY = (wr_state_r == WR_COLLECT) && !aw_held_r;
   assign S_AXI_WREADY = (wr_state_r == WR_COLLECT) && !w_held_r;
   assign S_AXI_BVALID = (wr_state_r == WR_RESPOND);
   assign S_AXI_BRESP = bresp_r;
   assign wr_commit = (wr_state_r == WR_COLLECT) && aw_held_r && w_held_r;

   // Next write state
   always_comb begin
      wr_state_nxt = wr_state_r;
      case (wr_state_r)
         WR_COLLECT: begin
            if (wr_commit) begin
               wr_state_nxt = WR_RESPOND;
            end
         end
         WR_RESPOND: begin
            if (S_AXI_BREADY) begin
               wr_state_nxt = WR_COLLECT;
            end
         end
         default: begin
            wr_state_nxt = WR_COLLECT;
         end
      endcase
   end

   // Write state register
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         wr_state_r <= WR_COLLECT;
      end else begin
         wr_state_r <= wr_state_nxt;
      end
   end

   // Capture address and data halves
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR;
         end else if (wr_commit) begin
            aw_held_r <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held_r <= 1'b1;
            w_data_r <= S_AXI_WDATA;
            w_strb_r <= S_AXI_WSTRB;
         end else if (wr_commit) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // Address decode for the pending write
   always_comb begin
      wr_hit_ctrl = 1'b0;
      wr_hit_icon = 1'b0;
      wr_hit_cmp = 1'b0;
      if (aw_addr_r[ADDR_W-1:2] == OFS_UNIT_CONTROL[ADDR_W-1:2]) begin
         wr_hit_ctrl = 1'b1;
      end else if (aw_addr_r[ADDR_W-1:2] == OFS_CURRENT_CONTROL[ADDR_W-1:2]) begin
         wr_hit_icon = 1'b1;
      end else if (aw_addr_r[ADDR_W-1:2] == OFS_COMPARATOR_CONTROL[ADDR_W-1:2]) begin
         wr_hit_cmp = 1'b1;
      end
   end

   // Only the two low byte lanes carry register bits
   // Upper data half is dropped
   assign wr_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

   // Write response: unmapped addresses answer SLVERR
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         bresp_r <= RESP_OKAY;
      end else if (wr_commit) begin
         bresp_r <= (wr_hit_ctrl || wr_hit_icon || wr_hit_cmp) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // ----------------------------------------------------------------
   // Control register, edge status flags included
   // ----------------------------------------------------------------
   // Status flags: hardware sets, a written zero clears, set wins the tie
   // Writing one sets no flag
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         ctrl_r <= unit_control_type'(RST_UNIT_CONTROL);
      end else begin
         if (wr_commit && wr_hit_ctrl) begin
            ctrl_r[15:2] <= ((w_data_r[15:2] & wr_mask[15:2]) | (ctrl_r[15:2] & ~wr_mask[15:2]))
                            & MASK_UNIT_CONTROL[15:2];
         end
         ctrl_r.first_edge_seen <= edge_one_event || (ctrl_r.first_edge_seen
            && !(wr_commit && wr_hit_ctrl && w_strb_r[0] && !w_data_r[0]));
         ctrl_r.second_edge_seen <= edge_two_event || (ctrl_r.second_edge_seen
            && !(wr_commit && wr_hit_ctrl && w_strb_r[0] && !w_data_r[1]));
      end
   end

   // ----------------------------------------------------------------
   // Current and comparator control registers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         icon_r <= current_control_type'(RST_CURRENT_CONTROL);
         cmp_r <= comparator_control_type'(RST_COMPARATOR_CONTROL);
      end else if (wr_commit) begin
         if (wr_hit_icon) begin
            // Reserved bits masked on entry
            icon_r <= current_control_type'(((w_data_r[15:0] & wr_mask) | (icon_r & ~wr_mask))
                                            & MASK_CURRENT_CONTROL);
         end
         if (wr_hit_cmp) begin
            cmp_r <= comparator_control_type'(((w_data_r[15:0] & wr_mask) | (cmp_r & ~wr_mask))
                                              & MASK_COMPARATOR_CONTROL);
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   // One read in flight; a new address waits until data is taken
   // Data one cycle after address
   assign S_AXI_ARREADY = !rvalid_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;

   // Read data, upper half always zero
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_r <= 1'b1;
         rresp_r <= RESP_OKAY;
         if (S_AXI_ARADDR[ADDR_W-1:2] == OFS_UNIT_CONTROL[ADDR_W-1:2]) begin
            rdata_r <= {16'h0000, ctrl_r & MASK_UNIT_CONTROL};
         end else if (S_AXI_ARADDR[ADDR_W-1:2] == OFS_CURRENT_CONTROL[ADDR_W-1:2]) begin
            rdata_r <= {16'h0000, icon_r & MASK_CURRENT_CONTROL};
         end else if (S_AXI_ARADDR[ADDR_W-1:2] == OFS_COMPARATOR_CONTROL[ADDR_W-1:2]) begin
            rdata_r <= {16'h0000, cmp_r & MASK_COMPARATOR_CONTROL};
         end else begin
            // Unmapped: zero data and a slave error
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_SLVERR;
         end
      end else if (rvalid_r && S_AXI_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule : charge_time_unit

//--- sim/charge_time_unit_checker.sv
`timescale 1ns/1ps
module charge_time_unit_checker (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // Register bus answers
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   // Comparator and charge path
   input wire logic IDLE_MODE,
   input wire logic COMPARATOR_OUT,
   input wire logic COMPARATOR_EVENT,
   input wire logic COMPARATOR_IRQ,
   input wire logic COMPARATOR_B_INPUT_ROUTE,
   input wire logic CHARGE_ENABLE,
   input wire logic DELAYED_PULSE_OUT
);
   // One clock domain, so one default for all
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!NRST);

   // Pulse follows the trip in the same cycle, no clock wait
   AST_PULSE_NOW: assert property (DELAYED_PULSE_OUT == (CHARGE_ENABLE && COMPARATOR_OUT))
      else $error("pulse output differs from charge and trip");
   // No charging unless delay mode is routed
   AST_CHARGE_ROUTED: assert property (!COMPARATOR_B_INPUT_ROUTE |-> !CHARGE_ENABLE)
      else $error("charging without delay routing");
   // Awake device passes every comparator request
   AST_IRQ_AWAKE: assert property (!IDLE_MODE |-> COMPARATOR_IRQ == COMPARATOR_EVENT)
      else $error("comparator request lost while awake");
   // Never a request without its cause
   AST_IRQ_CAUSE: assert property (COMPARATOR_IRQ |-> COMPARATOR_EVENT)
      else $error("comparator request without event");
   // Write answer stands until taken
   AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   // Read data stands until taken
   AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped early");
   // Read answer one cycle after the address
   AST_R_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   // No second address while data waits
   AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("address accepted during pending read");
endmodule : charge_time_unit_checker

bind charge_time_unit charge_time_unit_checker chk (
   .REF_CLK(REF_CLK), .NRST(NRST), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .IDLE_MODE(IDLE_MODE), .COMPARATOR_OUT(COMPARATOR_OUT), .COMPARATOR_EVENT(COMPARATOR_EVENT),
   .COMPARATOR_IRQ(COMPARATOR_IRQ), .COMPARATOR_B_INPUT_ROUTE(COMPARATOR_B_INPUT_ROUTE),
   .CHARGE_ENABLE(CHARGE_ENABLE), .DELAYED_PULSE_OUT(DELAYED_PULSE_OUT));

//--- sim/edge_partner.sv
`timescale 1ns/1ps
module edge_partner
   import charge_time_pkg::*;
#(
   parameter int TRIP = 6 // Charge cycles until the reference is crossed
) (
   // Clock
   input wire logic clk,
   // Current source controls
   input wire logic charge,
   input wire logic ground,
   input wire logic [1:0] range,
   // Edge sources and comparator
   output edge_sources_type src,
   output logic cmp_out
);
   int cap = 0; // Capacitor charge, in cycles
   initial src = '0;
   // Capacitor charges only from a live, ungrounded source
   always @(posedge clk) begin
      if (!charge || ground) begin
         cap <= 0;
      end else if (range != RANGE_OFF && cap < TRIP) begin
         cap <= cap + 1;
      end
   end
   // Trips once above the reference level
   assign cmp_out = (cap >= TRIP);
   // New source levels just after an edge
   task automatic drive(input logic [3:0] v);
      @(posedge clk);
      src <= v;
   endtask : drive
endmodule : edge_partner

//--- sim/tb.sv
`timescale 1ns/1ps
module tb
   import charge_time_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic idle = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, irq, route, charge, ground, pulse, trig, cmp;
   logic [1:0] bresp, rresp, range;
   logic [31:0] rdata;
   logic [5:0] trim;
   edge_sources_type src;
   int fails = 0, num_checks = 0, trig_count = 0;

   always #2 clk = ~clk;
   // Trigger pulses counted, they last one cycle
   always @(posedge clk) if (trig === 1'b1) trig_count <= trig_count + 1;

   charge_time_unit DUT (
      .REF_CLK(clk), .NRST(rst_n), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .IDLE_MODE(idle), .EDGE_PIN_ONE(src.edge_pin_one),
      .EDGE_PIN_TWO(src.edge_pin_two), .OUTPUT_COMPARE_ONE(src.output_compare_one),
      .TIMER_EDGE(src.timer_edge), .COMPARATOR_OUT(cmp), .COMPARATOR_EVENT(cmp),
      .COMPARATOR_IRQ(irq), .COMPARATOR_B_INPUT_ROUTE(route), .CHARGE_ENABLE(charge),
      .CURRENT_GROUND(ground), .CURRENT_TRIM(trim), .CURRENT_RANGE(range),
      .DELAYED_PULSE_OUT(pulse), .TRIGGER_OUT(trig));

   edge_partner far (.clk(clk), .charge(charge), .ground(ground), .range(range), .src(src),
      .cmp_out(cmp));

   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   // A hang counts as a mismatch and ends the run
   task automatic give_up(input int n);
      if (n > 200) begin
         fails++;
         wrap_up();
      end
   endtask : give_up

   // Write with address and data offered together
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge clk);
      awv <= 1'b1;
      awaddr <= a;
      wv <= 1'b1;
      wdata <= {16'h0000, d};
      forever begin
         @(posedge clk);
         if (awv && awready === 1'b1) awv <= 1'b0;
         if (wv && wready === 1'b1) wv <= 1'b0;
         if (bready && bvalid === 1'b1) begin
            check("bresp", 32'(bresp), 32'(er));
            bready <= 1'b0;
            break;
         end
         if (bvalid === 1'b1) bready <= 1'b1;
         give_up(++n);
      end
   endtask : wr

   // Read and compare one register word
   task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er);
      int n = 0;
      @(posedge clk);
      arv <= 1'b1;
      araddr <= a;
      forever begin
         @(posedge clk);
         if (arv && arready === 1'b1) arv <= 1'b0;
         if (rready && rvalid === 1'b1) begin
            check("rdata", rdata, {16'h0000, ed});
            check("rresp", 32'(rresp), 32'(er));
            rready <= 1'b0;
            break;
         end
         if (rvalid === 1'b1) rready <= 1'b1;
         give_up(++n);
      end
   endtask : rd

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rd(OFS_UNIT_CONTROL, RST_UNIT_CONTROL, RESP_OKAY);
      rd(OFS_CURRENT_CONTROL, RST_CURRENT_CONTROL, RESP_OKAY);
      rd(OFS_COMPARATOR_CONTROL, RST_COMPARATOR_CONTROL, RESP_OKAY);
      wr(OFS_CURRENT_CONTROL, 16'hFFFF, RESP_OKAY);
      rd(OFS_CURRENT_CONTROL, 16'hFF00, RESP_OKAY);
      check("trim", 32'(trim), 32'h0000_003F);
      check("range off", 32'(range), 32'h0000_0000);
      // Flags are not settable by software
      wr(OFS_UNIT_CONTROL, 16'hFFFF, RESP_OKAY);
      rd(OFS_UNIT_CONTROL, 16'hBFFC, RESP_OKAY);
      check("range on", 32'(range), 32'h0000_0003);
      check("ground", 32'(ground), 32'h0000_0001);
      idle <= 1'b1;
      rd(OFS_UNIT_CONTROL, 16'hBFFC, RESP_OKAY);
      check("range idle stop", 32'(range), 32'h0000_0000);
      wr(OFS_UNIT_CONTROL, 16'h9FFC, RESP_OKAY);
      rd(OFS_UNIT_CONTROL, 16'h9FFC, RESP_OKAY);
      check("range idle run", 32'(range), 32'h0000_0003);
      idle <= 1'b0;
      wr(OFS_COMPARATOR_CONTROL, 16'hFFFF, RESP_OKAY);
      rd(OFS_COMPARATOR_CONTROL, 16'h8000, RESP_OKAY);
      wr(8'h0C, 16'h1234, RESP_SLVERR);
      rd(8'h0C, 16'h0000, RESP_SLVERR);
      // Base range, no trim, ungrounded, unit off
      wr(OFS_UNIT_CONTROL, 16'h0000, RESP_OKAY);
      wr(OFS_CURRENT_CONTROL, 16'h0100, RESP_OKAY);
   endtask : t_regs

   // Both channels on one source; one edge charges and fires the pulse
   task automatic t_edge(input logic [1:0] s, input logic p);
      int n = 0;
      int t0;
      far.drive({4{~p}});
      wr(OFS_UNIT_CONTROL, {8'b1001_1001, p, s, p, s, 2'b00}, RESP_OKAY);
      t0 = trig_count;
      far.drive({4{~p}} ^ (4'b0001 << s));
      while (pulse !== 1'b1) begin
         @(posedge clk);
         give_up(++n);
      end
      check("charge", 32'(charge), 32'h0000_0001);
      check("route", 32'(route), 32'h0000_0001);
      check("irq", 32'(irq), 32'h0000_0001);
      idle <= 1'b1;
      @(posedge clk);
      check("irq idle", 32'(irq), 32'h0000_0000);
      idle <= 1'b0;
      rd(OFS_UNIT_CONTROL, {8'b1001_1001, p, s, p, s, 2'b11}, RESP_OKAY);
      check("trigger", 32'(trig_count - t0), 32'h0000_0001);
   endtask : t_edge

   // A stopped unit, blocked edges, then ordering between the channels
   task automatic t_order();
      logic [15:0] c;
      for (int k = 0; k < 3; k++) begin
         c = {k == 0 ? 4'b0001 : 4'b1001, k == 1 ? 4'b0101 : 4'b1101, 8'b1101_1100};
         far.drive(4'b0000);
         wr(OFS_UNIT_CONTROL, c, RESP_OKAY);
         far.drive(4'b0100);
         rd(OFS_UNIT_CONTROL, c, RESP_OKAY);
      end
      far.drive(4'b1000);
      far.drive(4'b1100);
      rd(OFS_UNIT_CONTROL, c | 16'h0003, RESP_OKAY);
      wstrb <= 4'h2;
      wr(OFS_UNIT_CONTROL, c, RESP_OKAY);
      wstrb <= 4'hF;
      rd(OFS_UNIT_CONTROL, c | 16'h0003, RESP_OKAY);
      wr(OFS_UNIT_CONTROL, c, RESP_OKAY);
      rd(OFS_UNIT_CONTROL, c, RESP_OKAY);
   endtask : t_order

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      for (int s = 0; s < 4; s++) begin
         t_edge(2'(s), 1'b1);
         t_edge(2'(s), 1'b0);
      end
      t_order();
      wrap_up();
   end
endmodule : tb
